// >>> design/csst_regs.sv
// Status, interrupt and test registers of the clock switch
`timescale 1ns/1ps
`default_nettype none
module csst_regs #(
   parameter int FW = csst_pkg::FREQ_W
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire csst_pkg::csst_req_t  req_i,
   output logic [7:0]                rdata_o,
   input  wire csst_pkg::csst_valid_t valid_i,
   input  wire logic                 ref_pin_i,
   input  wire logic                 main_ref_cycle_missed_i,
   input  wire logic [2:0]           main_loop_state_i,
   input  wire logic                 sync_monitor_alarm_i,
   input  wire csst_pkg::csst_loss_t aux_loss_i,
   input  wire csst_pkg::csst_loss_t loss_enable_i,
   input  wire logic [FW-1:0]        main_loop_offset_i,
   input  wire logic [FW-1:0]        aux_loop_offset_i,
   input  wire logic [FW-2:0]        main_hard_limit_i,
   input  wire logic [FW-2:0]        main_soft_limit_i,
   input  wire logic [FW-2:0]        aux_hard_limit_i,
   input  wire logic [FW-2:0]        aux_soft_limit_i,
   input  wire logic                 readout_loop_select_i,
   output logic                      input_edge_select_o,
   output logic                      ref_edge_o,
   output logic [FW-1:0]             main_loop_track_o,
   output logic [FW-1:0]             aux_loop_track_o,
   output logic                      main_freq_sat_o
);
   import csst_pkg::*;

   // Magnitude of a two's complement offset
   function automatic logic [FW-2:0] mag(input logic [FW-1:0] v);
      logic [FW-1:0] n;
      n = v[FW-1] ? (~v + 1'b1) : v;
      return n[FW-2:0];
   endfunction : mag

   // Offset held to within plus or minus the limit
   function automatic logic [FW-1:0] clamp(input logic [FW-1:0] v, input logic [FW-2:0] lim);
      logic [FW-1:0] l;
      l = {1'b0, lim};
      if (mag(v) <= lim)
         return v;
      else
         return v[FW-1] ? (~l + 1'b1) : l;
   endfunction : clamp

   logic [7:0]  test_one_ff;
   logic [7:0]  irq_low_ff;
   logic [7:0]  irq_mid_ff;
   logic [7:0]  irq_high_ff;
   logic [7:0]  rdata_ff;
   csst_valid_t valid_prev_ff;
   logic [2:0]  state_prev_ff;
   logic [1:0]  miss_cnt_ff;
   logic        sync_prev_ff;
   logic        coarse_hold_ff;
   logic        aux_lock_ff;
   logic        main_soft_ff;
   logic        aux_soft_ff;
   logic        main_sat_ff;
   logic        aux_sat_ff;
   logic [FW-1:0] main_track_ff;
   logic [FW-1:0] aux_track_ff;
   logic [2:0]  pin_sync_ff;
   logic        ref_edge_ff;
   logic        ready_ff;

   logic [4:0]  in_change;
   logic        ref_fail_set;
   logic        opmode_set;
   logic        sync_set;
   logic        main_quiet;
   logic [7:0]  wclr_low;
   logic [7:0]  wclr_mid;
   logic [7:0]  wclr_high;
   logic [7:0]  nxt_irq_low;
   logic [7:0]  nxt_irq_mid;
   logic [7:0]  nxt_irq_high;
   logic [7:0]  nxt_rdata;
   logic [7:0]  status;
   logic [FW-1:0] sel_offset;

   // Events for the sticky flags
   assign in_change    = valid_i ^ valid_prev_ff;
   assign main_quiet   = (main_loop_state_i == ST_FREE_RUN) ||
                         (main_loop_state_i == ST_HOLDOVER);
   assign ref_fail_set = main_ref_cycle_missed_i && !main_quiet &&
                         (miss_cnt_ff == MISS_LIMIT - 2'h1);
   // First cycle after reset has no valid history to compare against
   assign opmode_set   = ready_ff && (main_loop_state_i != state_prev_ff);
   assign sync_set     = sync_monitor_alarm_i && !sync_prev_ff;

   // Write-one clear strobes
   assign wclr_low  = (req_i.wr && req_i.addr == ADDR_IRQ_LOW)  ? req_i.wdata : 8'h00;
   assign wclr_mid  = (req_i.wr && req_i.addr == ADDR_IRQ_MID)  ? req_i.wdata : 8'h00;
   assign wclr_high = (req_i.wr && req_i.addr == ADDR_IRQ_HIGH) ? req_i.wdata : 8'h00;

   // Set beats clear so an event in the clearing cycle is kept
   always_comb begin
      nxt_irq_low  = (irq_low_ff & ~wclr_low) & MSK_IRQ_LOW;
      nxt_irq_low[POS_IN_LOW +: 4] = nxt_irq_low[POS_IN_LOW +: 4] | in_change[3:0];
      nxt_irq_mid  = (irq_mid_ff & ~wclr_mid) & MSK_IRQ_MID;
      nxt_irq_mid[POS_STANDBY]  = nxt_irq_mid[POS_STANDBY] | in_change[4];
      nxt_irq_mid[POS_REF_FAIL] = nxt_irq_mid[POS_REF_FAIL] | ref_fail_set;
      nxt_irq_mid[POS_OPMODE]   = nxt_irq_mid[POS_OPMODE] | opmode_set;
      nxt_irq_high = (irq_high_ff & ~wclr_high) & MSK_IRQ_HIGH;
      nxt_irq_high[POS_SYNC]    = nxt_irq_high[POS_SYNC] | sync_set;
   end

   // Interrupt flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_low_ff  <= RST_IRQ_LOW & MSK_IRQ_LOW;
         irq_mid_ff  <= RST_IRQ_MID & MSK_IRQ_MID;
         irq_high_ff <= RST_IRQ_HIGH & MSK_IRQ_HIGH;
      end else begin
         irq_low_ff  <= nxt_irq_low;
         irq_mid_ff  <= nxt_irq_mid;
         irq_high_ff <= nxt_irq_high;
      end
   end

   // Event history
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_prev_ff <= '0;
         state_prev_ff <= ST_FREE_RUN;
         sync_prev_ff  <= 1'b0;
         ready_ff      <= 1'b0;
      end else begin
         valid_prev_ff <= valid_i;
         state_prev_ff <= main_loop_state_i;
         sync_prev_ff  <= sync_monitor_alarm_i;
         ready_ff      <= 1'b1;
      end
   end

   // Consecutive missing reference cycles; a seen edge or quiet state restarts it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         miss_cnt_ff <= 2'h0;
      end else if (ref_edge_ff || main_quiet) begin
         miss_cnt_ff <= 2'h0;
      end else if (main_ref_cycle_missed_i && miss_cnt_ff != MISS_LIMIT) begin
         miss_cnt_ff <= miss_cnt_ff + 2'h1;
      end
   end

   // Test register one; test register two accepts writes and stores nothing
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         test_one_ff <= RST_TEST_ONE;
      end else if (req_i.wr && req_i.addr == ADDR_TEST_ONE) begin
         test_one_ff <= req_i.wdata;
      end
   end

   // Reference pin synchroniser and chosen edge detector
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_sync_ff <= 3'h0;
         ref_edge_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], ref_pin_i};
         ref_edge_ff <= test_one_ff[POS_EDGE_SEL] ? (pin_sync_ff[1] && !pin_sync_ff[2])
                                                  : (!pin_sync_ff[1] && pin_sync_ff[2]);
      end
   end

   // Coarse loss latch, released only by dropping its enable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         coarse_hold_ff <= 1'b0;
      end else if (!loss_enable_i.coarse) begin
         coarse_hold_ff <= 1'b0;
      end else if (aux_loss_i.coarse) begin
         coarse_hold_ff <= 1'b1;
      end
   end

   // Frequency limiting and soft alarms for both loops
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_track_ff <= '0;
         aux_track_ff  <= '0;
         main_sat_ff   <= 1'b0;
         aux_sat_ff    <= 1'b0;
         main_soft_ff  <= 1'b0;
         aux_soft_ff   <= 1'b0;
      end else begin
         main_track_ff <= clamp(main_loop_offset_i, main_hard_limit_i);
         aux_track_ff  <= clamp(aux_loop_offset_i, aux_hard_limit_i);
         main_sat_ff   <= mag(main_loop_offset_i) >= main_hard_limit_i;
         aux_sat_ff    <= mag(aux_loop_offset_i) >= aux_hard_limit_i;
         main_soft_ff  <= mag(main_loop_offset_i) > main_soft_limit_i;
         aux_soft_ff   <= mag(aux_loop_offset_i) > aux_soft_limit_i;
      end
   end

   // Auxiliary lock: any enabled loss source, or the held coarse loss, means unlocked
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aux_lock_ff <= 1'b0;
      end else begin
         aux_lock_ff <= !((aux_loss_i.fine && loss_enable_i.fine) ||
                          (aux_loss_i.noact && loss_enable_i.noact) ||
                          (aux_sat_ff && loss_enable_i.freqlim) ||
                          (aux_loss_i.coarse && loss_enable_i.coarse) ||
                          coarse_hold_ff);
      end
   end

   // Status byte and readout
   assign sel_offset = readout_loop_select_i ? aux_loop_offset_i : main_loop_offset_i;
   assign status = {sync_monitor_alarm_i, aux_lock_ff, main_soft_ff, aux_soft_ff,
                    1'b0, main_loop_state_i};

   // Unused flag bits read as their fixed default; unknown addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (req_i.rd) begin
         unique case (req_i.addr)
            ADDR_TEST_ONE: nxt_rdata = test_one_ff;
            ADDR_IRQ_LOW:  nxt_rdata = irq_low_ff | (RST_IRQ_LOW & ~MSK_IRQ_LOW);
            ADDR_IRQ_MID:  nxt_rdata = irq_mid_ff | (RST_IRQ_MID & ~MSK_IRQ_MID);
            ADDR_FREQ_TOP: nxt_rdata = {5'h00, sel_offset[FW-1 -: 3]};
            ADDR_IRQ_HIGH: nxt_rdata = irq_high_ff | (RST_IRQ_HIGH & ~MSK_IRQ_HIGH);
            ADDR_STATUS:   nxt_rdata = status;
            default:       nxt_rdata = 8'h00;
         endcase
      end
   end

   // Read data register, held between reads
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= 8'h00;
      end else if (req_i.rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o             = rdata_ff;
   assign input_edge_select_o = test_one_ff[POS_EDGE_SEL];
   assign ref_edge_o          = ref_edge_ff;
   assign main_loop_track_o   = main_track_ff;
   assign aux_loop_track_o    = aux_track_ff;
   assign main_freq_sat_o     = main_sat_ff;
endmodule : csst_regs
`default_nettype wire

// >>> design/csst_pkg.sv
// Package of constants and types for the clock switch status and interrupt registers
// Functional notes
// - Test register bit 2 picks the input edge the main loop locks to, 0 falling and 1 rising.
// - Each of the five inputs sets its own sticky flag when it changes between valid and invalid.
// - Status bit 7 shows the live frame-sync alarm and reaching the alarm latches a sticky flag.
// - Status bit 6 shows only locked (1) or unlocked (0) for the auxiliary loop.
// - Auxiliary lock comes from fine, coarse, no-activity and frequency-limit losses, each enabled.
// - A coarse phase loss holds the auxiliary lock bit at 0 until the coarse enable is cleared.
// - Each loop stops tracking beyond its hard limit and flags an alarm beyond its soft limit.
// - Status bit 5 is 1 while the main loop tracks beyond its soft limit.
// - Status bit 4 is 1 while the auxiliary loop tracks beyond its soft limit.
// - The main loop state shows as 001 free run, 010 holdover, 100 locked, 101, 110 and 111.
package csst_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_TEST_ONE = 8'h03;
   localparam logic [7:0] ADDR_TEST_TWO = 8'h04;
   localparam logic [7:0] ADDR_IRQ_LOW  = 8'h05;
   localparam logic [7:0] ADDR_IRQ_MID  = 8'h06;
   localparam logic [7:0] ADDR_FREQ_TOP = 8'h07;
   localparam logic [7:0] ADDR_IRQ_HIGH = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h09;
   // Reset values
   localparam logic [7:0] RST_TEST_ONE  = 8'h14;
   localparam logic [7:0] RST_IRQ_LOW   = 8'hff;
   localparam logic [7:0] RST_IRQ_MID   = 8'h3f;
   localparam logic [7:0] RST_IRQ_HIGH  = 8'h10;
   // Implemented flag bits in each interrupt register
   localparam logic [7:0] MSK_IRQ_LOW   = 8'h3c;
   localparam logic [7:0] MSK_IRQ_MID   = 8'hc1;
   localparam logic [7:0] MSK_IRQ_HIGH  = 8'h80;
   // Field positions
   localparam int POS_EDGE_SEL  = 2;
   localparam int POS_OPMODE    = 7;
   localparam int POS_REF_FAIL  = 6;
   localparam int POS_STANDBY   = 0;
   localparam int POS_SYNC      = 7;
   localparam int POS_AUX_LOCK  = 6;
   localparam int POS_MAIN_SOFT = 5;
   localparam int POS_AUX_SOFT  = 4;
   localparam int POS_IN_LOW    = 2;
   localparam int FREQ_W        = 19;
   // Missing cycles before the reference failure flag
   localparam logic [1:0] MISS_LIMIT = 2'h2;

   // Main loop states as reported
   localparam logic [2:0] ST_FREE_RUN = 3'h1;
   localparam logic [2:0] ST_HOLDOVER = 3'h2;

   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csst_req_t;

   // Input validity, order: standby, b diff, a diff, b single, a single
   typedef struct packed {
      logic standby_input;
      logic input_b_differential;
      logic input_a_differential;
      logic input_b_single_ended;
      logic input_a_single_ended;
   } csst_valid_t;

   // Auxiliary loop phase loss sources or their enables
   typedef struct packed {
      logic fine;
      logic coarse;
      logic noact;
      logic freqlim;
   } csst_loss_t;
endpackage : csst_pkg

// >>> testbench/csst_regs_asserts.sv
// Checker of read data, status fields and test bit relations of the status registers
`timescale 1ns/1ps
`default_nettype none
module csst_regs_asserts #(
   parameter int FW = csst_pkg::FREQ_W
) (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire csst_pkg::csst_req_t  req_i,
   input wire logic [7:0]           rdata_o,
   input wire logic [2:0]           main_loop_state_i,
   input wire logic                 sync_monitor_alarm_i,
   input wire csst_pkg::csst_loss_t aux_loss_i,
   input wire csst_pkg::csst_loss_t loss_enable_i,
   input wire logic [FW-1:0]        main_loop_offset_i,
   input wire logic [FW-1:0]        aux_loop_offset_i,
   input wire logic [FW-2:0]        main_soft_limit_i,
   input wire logic                 readout_loop_select_i,
   input wire logic                 input_edge_select_o
);
   import csst_pkg::*;
   logic rd_s;
   // Status read strobe, used by several relations
   assign rd_s = req_i.rd && req_i.addr == ADDR_STATUS;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   edge_sel_a: assert property (req_i.wr && req_i.addr == ADDR_TEST_ONE
      |=> input_edge_select_o == $past(req_i.wdata[2])) else $error("edge select not written");
   reserved_read_a: assert property (req_i.rd && req_i.addr == ADDR_TEST_TWO
      |=> rdata_o == 8'h00) else $error("reserved register read not zero");
   // Offsets held steady so that any internal register stage has settled
   freq_read_a: assert property (req_i.rd && req_i.addr == ADDR_FREQ_TOP && $stable(main_loop_offset_i)
      && $stable(aux_loop_offset_i) && $stable(readout_loop_select_i) |=> rdata_o == {5'h00,
      $past(readout_loop_select_i) ? $past(aux_loop_offset_i[FW-1:FW-3])
      : $past(main_loop_offset_i[FW-1:FW-3])}) else $error("frequency top bits wrong");
   state_field_a: assert property (rd_s && $stable(main_loop_state_i)
      |=> rdata_o[3:0] == {1'b0, $past(main_loop_state_i)}) else $error("state field wrong");
   sync_live_a: assert property (rd_s |=> rdata_o[7] == $past(sync_monitor_alarm_i))
      else $error("live sync alarm bit wrong");
   aux_fine_a: assert property ((aux_loss_i.fine && loss_enable_i.fine)[*2] ##0 rd_s
      |=> !rdata_o[6]) else $error("lock shown despite fine loss");
   aux_coarse_a: assert property ((aux_loss_i.coarse && loss_enable_i.coarse) ##1
      loss_enable_i.coarse[*2] ##0 rd_s |=> !rdata_o[6]) else $error("coarse loss not held");
   soft_main_a: assert property (rd_s && $stable(main_loop_offset_i) && $stable(main_soft_limit_i)
      && !main_loop_offset_i[FW-1] && main_loop_offset_i[FW-2:0] > main_soft_limit_i
      |=> rdata_o[5]) else $error("main soft alarm missing");
   // Main scenarios reached
   cover property (rd_s ##1 !rdata_o[6]);
   cover property (req_i.wr && req_i.addr == ADDR_IRQ_LOW && req_i.wdata != 8'h00);
   cover property (req_i.rd && req_i.addr == ADDR_FREQ_TOP && readout_loop_select_i);
endmodule : csst_regs_asserts
bind csst_regs csst_regs_asserts #(.FW(FW)) i_csst_regs_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .req_i(req_i), .rdata_o(rdata_o), .main_loop_state_i(main_loop_state_i),
   .sync_monitor_alarm_i(sync_monitor_alarm_i), .aux_loss_i(aux_loss_i),
   .loss_enable_i(loss_enable_i), .main_loop_offset_i(main_loop_offset_i),
   .aux_loop_offset_i(aux_loop_offset_i), .main_soft_limit_i(main_soft_limit_i),
   .readout_loop_select_i(readout_loop_select_i), .input_edge_select_o(input_edge_select_o));
`default_nettype wire

// >>> testbench/csst_regs_tb_top.sv
// Self-checking testbench of the status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module csst_regs_tb_top;
   import csst_pkg::*;
   logic        clk, rst, pin, miss, sync, sel, esel, redge, sat;
   csst_req_t   req;
   csst_valid_t valid;
   csst_loss_t  loss, en;
   logic [7:0]  rdata;
   logic [2:0]  state;
   logic [18:0] moff, aoff, mtrk, atrk;
   logic [17:0] mhard, msoft, ahard, asoft;
   int          failures, n_tests;
   csst_regs i_csst_regs (.clk_i(clk), .rst_i(rst), .req_i(req), .rdata_o(rdata), .valid_i(valid),
      .ref_pin_i(pin), .main_ref_cycle_missed_i(miss), .main_loop_state_i(state),
      .sync_monitor_alarm_i(sync), .aux_loss_i(loss), .loss_enable_i(en),
      .main_loop_offset_i(moff), .aux_loop_offset_i(aoff), .main_hard_limit_i(mhard),
      .main_soft_limit_i(msoft), .aux_hard_limit_i(ahard), .aux_soft_limit_i(asoft),
      .readout_loop_select_i(sel), .input_edge_select_o(esel), .ref_edge_o(redge),
      .main_loop_track_o(mtrk), .aux_loop_track_o(atrk), .main_freq_sat_o(sat));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Bus cycles: request held one cycle, launched off the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) req = {1'b1, 1'b0, a, d};
      @(negedge clk) req = '0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk) req = {1'b0, 1'b1, a, 8'h00};
      @(negedge clk) req = '0;
      chk($sformatf("register %h", a), rdata, e);
   endtask : rchk
   task automatic pulse_miss();
      @(negedge clk) miss = 1'b1;
      @(negedge clk) miss = 1'b0;
   endtask : pulse_miss
   // Edge pulses seen in a fixed span after moving the reference pin
   task automatic edges(input logic v, input logic [7:0] e);
      int n;
      n = 0;
      @(negedge clk) pin = v;
      repeat (8) @(negedge clk) n += int'(redge === 1'b1);
      chk("reference edge pulses", 8'(n), e);
   endtask : edges
   task automatic t_reset();
      rchk(ADDR_IRQ_LOW, 8'hff);
      rchk(ADDR_IRQ_MID, 8'h3f);
      rchk(ADDR_IRQ_HIGH, 8'h10);
      rchk(ADDR_FREQ_TOP, 8'h00);
      rchk(ADDR_TEST_ONE, 8'h14);
      chk("edge select", {7'h0, esel}, 8'h01);
      rchk(8'h0a, 8'h00);
   endtask : t_reset
   task automatic t_w1c();
      wr(ADDR_IRQ_LOW, 8'h00);
      rchk(ADDR_IRQ_LOW, 8'hff);
      wr(ADDR_IRQ_LOW, 8'hff);
      rchk(ADDR_IRQ_LOW, 8'hc3);
      wr(ADDR_IRQ_MID, 8'hff);
      rchk(ADDR_IRQ_MID, 8'h3e);
      wr(ADDR_TEST_TWO, 8'h00);
      rchk(ADDR_TEST_TWO, 8'h00);
   endtask : t_w1c
   task automatic t_valid();
      for (int i = 0; i < 5; i++) begin
         @(negedge clk) valid[i] = ~valid[i];
         if (i < 4) begin
            rchk(ADDR_IRQ_LOW, 8'hc3 | (8'h04 << i));
            wr(ADDR_IRQ_LOW, 8'h04 << i);
         end else begin
            rchk(ADDR_IRQ_MID, 8'h3f);
            wr(ADDR_IRQ_MID, 8'h01);
         end
      end
      // Event in the same cycle as the clear must win
      @(negedge clk) req = {1'b1, 1'b0, ADDR_IRQ_LOW, 8'h04};
      valid[0] = ~valid[0];
      @(negedge clk) req = '0;
      rchk(ADDR_IRQ_LOW, 8'hc7);
      wr(ADDR_IRQ_LOW, 8'h04);
      rchk(ADDR_IRQ_LOW, 8'hc3);
   endtask : t_valid
   task automatic t_state();
      logic [2:0] codes [6] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h1};
      foreach (codes[i]) begin
         @(negedge clk) state = codes[i];
         rchk(ADDR_STATUS, 8'h40 | 8'(codes[i]));
         rchk(ADDR_IRQ_MID, 8'hbe);
         wr(ADDR_IRQ_MID, 8'h80);
      end
   endtask : t_state
   task automatic t_ref_fail(input logic [2:0] st, input logic [7:0] e);
      @(negedge clk) state = st;
      wr(ADDR_IRQ_MID, 8'h80);
      pulse_miss();
      rchk(ADDR_IRQ_MID, 8'h3e);
      pulse_miss();
      rchk(ADDR_IRQ_MID, e);
      wr(ADDR_IRQ_MID, 8'hc0);
   endtask : t_ref_fail
   task automatic t_sync_aux();
      // Back to free run, the status reads below expect state code 001
      @(negedge clk) sync = 1'b1;
      state = 3'h1;
      rchk(ADDR_STATUS, 8'hc1);
      rchk(ADDR_IRQ_HIGH, 8'h90);
      wr(ADDR_IRQ_HIGH, 8'h80);
      rchk(ADDR_IRQ_HIGH, 8'h10);
      sync = 1'b0;
      @(negedge clk) loss.coarse = 1'b1;
      @(negedge clk) loss.coarse = 1'b0;
      rchk(ADDR_STATUS, 8'h01);
      rchk(ADDR_STATUS, 8'h01);
      @(negedge clk) en.coarse = 1'b0;
      // Latch drops one edge after the enable, lock bit one edge later
      @(negedge clk);
      rchk(ADDR_STATUS, 8'h41);
      en.coarse = 1'b1;
      rchk(ADDR_STATUS, 8'h41);
      @(negedge clk) loss = 4'hb;
      rchk(ADDR_STATUS, 8'h01);
      en = 4'h4;
      rchk(ADDR_STATUS, 8'h41);
      loss = 4'h0;
      en = 4'hf;
   endtask : t_sync_aux
   task automatic t_freq();
      @(negedge clk) moff = 19'h0a000;
      rchk(ADDR_STATUS, 8'h61);
      moff = 19'h08000;
      rchk(ADDR_STATUS, 8'h41);
      aoff = 19'h7a000;
      rchk(ADDR_STATUS, 8'h51);
      mhard = 18'h08000;
      moff = 19'h0a000;
      ahard = 18'h04000;
      repeat (3) @(negedge clk);
      chk("hard limit reached", {7'h0, sat}, 8'h01);
      chk("main track held", mtrk[15:8], 8'h80);
      chk("aux track held", atrk[15:8], 8'hc0);
      rchk(ADDR_STATUS, 8'h31);
      mhard = 18'h3ffff;
      ahard = 18'h3ffff;
      moff = 19'h50000;
      aoff = 19'h30000;
      rchk(ADDR_FREQ_TOP, 8'h05);
      sel = 1'b1;
      rchk(ADDR_FREQ_TOP, 8'h03);
   endtask : t_freq
   initial begin
      rst = 1'b1;
      req = '0;
      valid = '0;
      pin = 1'b0;
      miss = 1'b0;
      sync = 1'b0;
      sel = 1'b0;
      state = 3'h1;
      loss = '0;
      en = 4'hf;
      moff = '0;
      aoff = '0;
      mhard = 18'h3ffff;
      ahard = 18'h3ffff;
      msoft = 18'h08000;
      asoft = 18'h04000;
      failures = 0;
      n_tests = 0;
      // Rising edges counted, the clock's start from x would pass as a falling one
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      t_reset();
      t_w1c();
      t_valid();
      t_state();
      t_ref_fail(3'h4, 8'h7e);
      t_ref_fail(3'h2, 8'h3e);
      t_sync_aux();
      t_freq();
      edges(1'b1, 8'h01);
      edges(1'b0, 8'h00);
      wr(ADDR_TEST_ONE, 8'h10);
      chk("edge select", {7'h0, esel}, 8'h00);
      edges(1'b1, 8'h00);
      edges(1'b0, 8'h01);
      end_of_test();
   end
   // Watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule : csst_regs_tb_top
`default_nettype wire
